// File: rtl/pack_mode_charge_controller.v
`include "pack_ctrl_consts.vh"
module pack_mode_charge_controller #(
  parameter FLASHLIGHT = 0,
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // User pins
  input wire park_pin_i,
  input wire push_button_b_i,
  // Analog comparator flags
  input wire input_supply_valid_i,
  input wire out_undervolt_i,
  input wire bat_undervolt_i,
  input wire bat_above_precond_i,
  input wire bat_at_term_i,
  input wire chg_current_low_i,
  input wire bat_recharge_i,
  input wire bat_above_low_i,
  input wire [3:0] bat_above_level_i,
  // Switch enables
  output reg input_path_switch_o,
  output reg converter_buck_o,
  output reg converter_boost_o,
  output reg precond_current_o,
  output reg const_voltage_o,
  output reg flashlight_o,
  // Status
  output reg [1:0] mode_o,
  output reg [2:0] chg_state_o,
  output reg uv_latched_o,
  // Level lamps
  output reg level_lamp_1_o,
  output reg level_lamp_2_o,
  output reg level_lamp_3_o,
  output reg level_lamp_4_o
);
  localparam NSYNC = 14;
  localparam [1:0] MODE_PARK = `MODE_PARK;
  localparam [1:0] MODE_CHARGE = `MODE_CHARGE;
  localparam [1:0] MODE_BOOST = `MODE_BOOST;
  localparam [2:0] CHG_PRE = `CHG_PRE;
  localparam [2:0] CHG_FAST = `CHG_FAST;
  localparam [2:0] CHG_TOP = `CHG_TOP;
  localparam [2:0] CHG_EOC = `CHG_EOC;
  localparam [2:0] CHG_IDLE = `CHG_IDLE;
  localparam [12:0] PB_ON = `PB_ON_MS;
  localparam [12:0] PB_OFF = `PB_OFF_MS;
  localparam [12:0] PARK_WAIT = `PARK_WAIT_MS;
  localparam [12:0] HICCUP = `HICCUP_MS;
  localparam [12:0] FLASH_PB = `FLASH_PB_MS;
  localparam [12:0] FLASH_HALF = `FLASH_HALF_MS;
  localparam [12:0] SHOW = `SHOW_MS;

  wire tick;
  wire [NSYNC-1:0] raw;
  wire [NSYNC-1:0] syn;

  // Shared millisecond tick
  ms_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .tick_o(tick)
  );

  assign raw = {bat_above_level_i, bat_above_low_i, bat_recharge_i, chg_current_low_i, bat_at_term_i,
                bat_above_precond_i, bat_undervolt_i, out_undervolt_i, input_supply_valid_i,
                ~push_button_b_i, park_pin_i};

  // Input synchronisers
  flag_sync #(
    .WIDTH(NSYNC)
  ) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i(raw),
    .sync_o(syn)
  );

  wire park_s = syn[0];
  wire pressed_s = syn[1];
  wire vin_s = syn[2];
  wire out_uv_s = syn[3];
  wire bat_uv_s = syn[4];
  wire pre_ok_s = syn[5];
  wire term_s = syn[6];
  wire ilow_s = syn[7];
  wire rech_s = syn[8];
  wire low_ok_s = syn[9];
  wire [3:0] lvl_s = syn[13:10];

  // Push button hold timer and release edge
  reg [12:0] press_ms_r;
  reg pressed_d_r;
  reg press_used_r;
  reg flash_used_r;
  wire release_ev = pressed_d_r & ~pressed_s;

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      press_ms_r <= 13'h0000;
      pressed_d_r <= 1'b0;
    end else begin
      pressed_d_r <= pressed_s;
      if (!pressed_s) begin
        press_ms_r <= 13'h0000;
      end else if (tick && press_ms_r != 13'h1FFF) begin
        press_ms_r <= press_ms_r + 13'h0001;
      end
    end
  end

  // Hold thresholds; on and off share one arming flag so only one fires per press, flash has its own
  wire hold_on = pressed_s && press_ms_r > PB_ON && !press_used_r;
  wire hold_off = pressed_s && press_ms_r > PB_OFF && !press_used_r;
  wire hold_flash = pressed_s && press_ms_r >= FLASH_PB && !flash_used_r;

  // Mode state machine
  reg [1:0] mode_r;
  reg [1:0] mode_nxt;
  reg [1:0] target_r;
  reg [12:0] wait_ms_r;
  reg boost_req_r;
  reg uv_latch_r;
  reg vin_d_r;
  reg [12:0] hic_ms_r;
  reg hiccup_r;

  // Requested mode from pins
  wire [1:0] want = vin_s ? MODE_CHARGE :
                    (park_s || uv_latch_r || !boost_req_r) ? MODE_PARK : MODE_BOOST;

  always @* begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_PARK: begin
        if (want != MODE_PARK && wait_ms_r >= PARK_WAIT) begin
          mode_nxt = want;
        end
      end
      MODE_CHARGE: begin
        if (want != MODE_CHARGE) begin
          mode_nxt = MODE_PARK;
        end
      end
      MODE_BOOST: begin
        if (want != MODE_BOOST) begin
          mode_nxt = MODE_PARK;
        end
      end
      default: begin
        mode_nxt = MODE_PARK;
      end
    endcase
  end

  // Mode, park wait, boost request and undervoltage latch
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      mode_r <= MODE_PARK;
      target_r <= MODE_PARK;
      wait_ms_r <= 13'h0000;
      boost_req_r <= 1'b0;
      uv_latch_r <= 1'b0;
      vin_d_r <= 1'b0;
      press_used_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      target_r <= want;
      vin_d_r <= vin_s;
      if (mode_nxt != MODE_PARK || mode_r != MODE_PARK) begin
        wait_ms_r <= 13'h0000;
      end else if (tick && wait_ms_r != 13'h1FFF) begin
        wait_ms_r <= wait_ms_r + 13'h0001;
      end
      // Latch in boost, released only by fresh input power
      if (mode_r == MODE_BOOST && bat_uv_s) begin
        uv_latch_r <= 1'b1;
      end else if (vin_s && !vin_d_r) begin
        uv_latch_r <= 1'b0;
      end
      if (!pressed_s) begin
        press_used_r <= 1'b0;
      end
      if (park_s || vin_s || uv_latch_r) begin
        boost_req_r <= 1'b0;
      end else if (!boost_req_r && hold_on) begin
        boost_req_r <= 1'b1;
        press_used_r <= 1'b1;
      end else if (FLASHLIGHT == 0 && boost_req_r && mode_r == MODE_BOOST && hold_off) begin
        boost_req_r <= 1'b0;
        press_used_r <= 1'b1;
      end else if (FLASHLIGHT != 0 && hold_flash) begin
        press_used_r <= 1'b1;
      end
    end
  end

  // Input path hiccup on output undervoltage
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      hiccup_r <= 1'b0;
      hic_ms_r <= 13'h0000;
    end else if (mode_r != MODE_CHARGE) begin
      hiccup_r <= 1'b0;
      hic_ms_r <= 13'h0000;
    end else if (!hiccup_r && out_uv_s) begin
      hiccup_r <= 1'b1;
      hic_ms_r <= 13'h0000;
    end else if (hiccup_r && tick) begin
      if (hic_ms_r >= HICCUP - 13'h0001) begin
        hiccup_r <= 1'b0;
      end else begin
        hic_ms_r <= hic_ms_r + 13'h0001;
      end
    end
  end

  // Flashlight toggle, own arming flag so a boost start cannot swallow it
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      flashlight_o <= 1'b0;
      flash_used_r <= 1'b0;
    end else if (!pressed_s) begin
      flash_used_r <= 1'b0;
    end else if (FLASHLIGHT != 0 && hold_flash) begin
      flashlight_o <= ~flashlight_o;
      flash_used_r <= 1'b1;
    end
  end

  // Charger state machine
  reg [2:0] chg_r;
  reg [2:0] chg_nxt;

  always @* begin
    chg_nxt = chg_r;
    case (chg_r)
      CHG_IDLE: begin
        if (mode_r == MODE_CHARGE) begin
          chg_nxt = CHG_PRE;
        end
      end
      CHG_PRE: begin
        if (pre_ok_s) begin
          chg_nxt = CHG_FAST;
        end
      end
      CHG_FAST: begin
        if (term_s) begin
          chg_nxt = CHG_TOP;
        end
      end
      CHG_TOP: begin
        if (ilow_s) begin
          chg_nxt = CHG_EOC;
        end
      end
      CHG_EOC: begin
        if (rech_s) begin
          chg_nxt = CHG_FAST;
        end
      end
      default: begin
        chg_nxt = CHG_IDLE;
      end
    endcase
    if (mode_r != MODE_CHARGE) begin
      chg_nxt = CHG_IDLE;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      chg_r <= CHG_IDLE;
    end else begin
      chg_r <= chg_nxt;
    end
  end

  // Flash phase and display window
  reg [12:0] flash_ms_r;
  reg blink_r;
  reg [12:0] show_ms_r;
  reg show_r;

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      flash_ms_r <= 13'h0000;
      blink_r <= 1'b1;
      show_ms_r <= 13'h0000;
      show_r <= 1'b0;
    end else begin
      if (tick) begin
        if (flash_ms_r >= FLASH_HALF - 13'h0001) begin
          flash_ms_r <= 13'h0000;
          blink_r <= ~blink_r;
        end else begin
          flash_ms_r <= flash_ms_r + 13'h0001;
        end
      end
      if (FLASHLIGHT == 0 && release_ev) begin
        show_r <= 1'b1;
        show_ms_r <= 13'h0000;
      end else if (show_r && tick) begin
        if (show_ms_r >= SHOW - 13'h0001) begin
          show_r <= 1'b0;
        end else begin
          show_ms_r <= show_ms_r + 13'h0001;
        end
      end
    end
  end

  // Lamp pattern
  reg [3:0] solid;
  reg [3:0] flash;
  reg [3:0] lamps;
  reg lit;
  integer i;

  always @* begin
    solid = 4'h0;
    flash = 4'h0;
    lit = (mode_r == MODE_CHARGE) || mode_r == MODE_BOOST || show_r || FLASHLIGHT != 0;
    if (mode_r == MODE_CHARGE && chg_r == CHG_EOC) begin
      solid = 4'hF;
    end else if (mode_r == MODE_CHARGE) begin
      solid = lvl_s;
      flash = 4'h1;
      for (i = 1; i < 4; i = i + 1) begin
        if (lvl_s[i-1]) begin
          flash = 4'h1 << i;
        end
      end
      if (lvl_s[3]) begin
        solid = 4'h7;
        flash = 4'h8;
      end
    end else if (lvl_s[0]) begin
      solid = lvl_s;
    end else if (low_ok_s) begin
      flash = 4'h1;
    end
    lamps = lit ? (solid | (flash & {4{blink_r}})) : 4'h0;
  end

  // Registered outputs
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      input_path_switch_o <= 1'b0;
      converter_buck_o <= 1'b0;
      converter_boost_o <= 1'b0;
      precond_current_o <= 1'b0;
      const_voltage_o <= 1'b0;
      mode_o <= MODE_PARK;
      chg_state_o <= CHG_IDLE;
      uv_latched_o <= 1'b0;
      level_lamp_1_o <= 1'b0;
      level_lamp_2_o <= 1'b0;
      level_lamp_3_o <= 1'b0;
      level_lamp_4_o <= 1'b0;
    end else begin
      input_path_switch_o <= (mode_r == MODE_CHARGE) && !hiccup_r;
      converter_buck_o <= (mode_r == MODE_CHARGE) && (chg_r != CHG_EOC) && (chg_r != CHG_IDLE);
      converter_boost_o <= (mode_r == MODE_BOOST);
      precond_current_o <= (mode_r == MODE_CHARGE) && (chg_r == CHG_PRE);
      const_voltage_o <= (mode_r == MODE_CHARGE) && (chg_r == CHG_TOP);
      mode_o <= mode_r;
      chg_state_o <= chg_r;
      uv_latched_o <= uv_latch_r;
      level_lamp_1_o <= lamps[0];
      level_lamp_2_o <= lamps[1];
      level_lamp_3_o <= lamps[2];
      level_lamp_4_o <= lamps[3];
    end
  end
endmodule

// File: common/pack_ctrl_consts.vh
`ifndef PACK_CTRL_CONSTS_VH
`define PACK_CTRL_CONSTS_VH
// Clock period in picoseconds (200 MHz)
`define CLK_PERIOD_PS 5000
// Tick period in microseconds (1 ms tick)
`define TICK_US 1000
`define TICK_CYCLES ((`TICK_US * 1000000) / `CLK_PERIOD_PS)
// Times in milliseconds
`define PB_ON_MS 30
`define PB_OFF_MS 1500
`define PARK_WAIT_MS 2000
`define HICCUP_MS 2000
`define FLASH_PB_MS 3000
`define FLASH_HALF_MS 1000
`define SHOW_MS 5000
// Mode codes
`define MODE_PARK 2'h0
`define MODE_CHARGE 2'h1
`define MODE_BOOST 2'h2
// Charger state codes
`define CHG_PRE 3'h0
`define CHG_FAST 3'h1
`define CHG_TOP 3'h2
`define CHG_EOC 3'h3
`define CHG_IDLE 3'h4
`endif

// File: rtl/flag_sync.v
module flag_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Asynchronous flags in, synchronised out
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // Two flop chain per bit
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule

// File: rtl/ms_tick.v
`include "pack_ctrl_consts.vh"
module ms_tick #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // One cycle pulse per millisecond
  output reg tick_o
);
  reg [31:0] cnt_r;

  // Prescaler down to the common tick
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_r <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else if (cnt_r >= TICK_CYCLES - 1) begin
      cnt_r <= 32'h0000_0000;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
      tick_o <= 1'b0;
    end
  end
endmodule

// File: sim/power_stage_model.sv
module power_stage_model (
  // Cell level code and stage controls
  input wire logic [2:0] lvl_i,
  input wire logic ovl_i,
  input wire logic path_i,
  input wire logic cv_i,
  // Comparator flags
  output wire logic out_uv_o,
  output wire logic bat_uv_o,
  output wire logic precond_o,
  output wire logic term_o,
  output wire logic cur_low_o,
  output wire logic recharge_o,
  output wire logic low_o,
  output wire logic [3:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Overload sags the output only while the input path feeds it
  assign out_uv_o = ovl_i && path_i;
  // Cell comparators, code 0 below 2.9V up to 6 at termination
  assign bat_uv_o = lvl_i == 3'h0;
  assign low_o = lvl_i != 3'h0;
  assign precond_o = lvl_i >= 3'h2;
  assign term_o = lvl_i == 3'h6;
  assign recharge_o = lvl_i <= 3'h4;
  assign level_o = {lvl_i >= 3'h5, lvl_i >= 3'h4, lvl_i >= 3'h3, lvl_i >= 3'h2};
  // Current tapers only under voltage regulation at termination
  assign cur_low_o = cv_i && term_o;
endmodule

// File: sim/pack_mode_properties.sv
`include "pack_ctrl_consts.vh"
module pack_mode_props #(
  parameter TICK_CYCLES = 4
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire park_pin_i,
  input wire input_supply_valid_i,
  input wire input_path_switch_o,
  input wire converter_buck_o,
  input wire converter_boost_o,
  input wire const_voltage_o,
  input wire [1:0] mode_o,
  input wire [2:0] chg_state_o,
  input wire uv_latched_o,
  input wire level_lamp_1_o,
  input wire level_lamp_2_o,
  input wire level_lamp_3_o,
  input wire level_lamp_4_o
);
  localparam int MIN_WAIT = 1990 * TICK_CYCLES;
  int park_cnt;
  int off_cnt;
  int vin_low_cnt;
  // Cycles spent in park, with the path off and with no supply
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      park_cnt <= 0;
      off_cnt <= 0;
      vin_low_cnt <= 0;
    end else begin
      park_cnt <= (mode_o == `MODE_PARK) ? park_cnt + 1 : 0;
      off_cnt <= input_path_switch_o ? 0 : off_cnt + 1;
      vin_low_cnt <= input_supply_valid_i ? 0 : vin_low_cnt + 1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_path_boost_excl: assert property (!(input_path_switch_o && converter_boost_o))
    else $error("input path and boost both on");
  a_park_all_off: assert property (mode_o == `MODE_PARK && $past(mode_o) == `MODE_PARK |->
    !input_path_switch_o && !converter_buck_o && !converter_boost_o) else $error("switch on in park");
  a_via_park: assert property ($changed(mode_o) && $past(mode_o) != `MODE_PARK |-> mode_o == `MODE_PARK)
    else $error("mode change skipped park");
  a_park_dwell: assert property ($past(mode_o) == `MODE_PARK && mode_o != `MODE_PARK |-> park_cnt >= MIN_WAIT)
    else $error("park left too early");
  a_vin_charge: assert property (input_supply_valid_i [*8] |-> mode_o != `MODE_BOOST)
    else $error("boost with valid supply");
  a_pin_parks: assert property ((park_pin_i && !input_supply_valid_i) [*8] |-> mode_o != `MODE_BOOST)
    else $error("boost with park pin high");
  a_uv_park: assert property (uv_latched_o && $past(uv_latched_o) |-> mode_o != `MODE_BOOST)
    else $error("boost while latched");
  a_uv_holds: assert property (uv_latched_o && vin_low_cnt >= 6 |=> uv_latched_o)
    else $error("latch cleared without supply");
  a_chg_order: assert property ($changed(chg_state_o) |-> chg_state_o == `CHG_IDLE ||
    (chg_state_o == `CHG_PRE && $past(chg_state_o) == `CHG_IDLE) ||
    (chg_state_o == `CHG_FAST && ($past(chg_state_o) == `CHG_PRE || $past(chg_state_o) == `CHG_EOC)) ||
    (chg_state_o == `CHG_TOP && $past(chg_state_o) == `CHG_FAST) ||
    (chg_state_o == `CHG_EOC && $past(chg_state_o) == `CHG_TOP)) else $error("charge step out of order");
  a_cv_topoff: assert property (const_voltage_o |-> chg_state_o == `CHG_TOP || $past(chg_state_o) == `CHG_TOP)
    else $error("voltage mode outside top-off");
  a_eoc_solid: assert property (chg_state_o == `CHG_EOC [*3] |->
    {level_lamp_4_o, level_lamp_3_o, level_lamp_2_o, level_lamp_1_o} == 4'hf) else $error("lamps not solid");
  a_hiccup_wait: assert property ($rose(input_path_switch_o) |-> off_cnt >= MIN_WAIT)
    else $error("input path retried too soon");
endmodule
bind pack_mode_charge_controller pack_mode_props #(.TICK_CYCLES(TICK_CYCLES)) props_u (.clk_i(clk_i),
  .rst_b_i(rst_b_i), .park_pin_i(park_pin_i), .input_supply_valid_i(input_supply_valid_i),
  .input_path_switch_o(input_path_switch_o), .converter_buck_o(converter_buck_o),
  .converter_boost_o(converter_boost_o), .const_voltage_o(const_voltage_o), .mode_o(mode_o),
  .chg_state_o(chg_state_o), .uv_latched_o(uv_latched_o), .level_lamp_1_o(level_lamp_1_o),
  .level_lamp_2_o(level_lamp_2_o), .level_lamp_3_o(level_lamp_3_o), .level_lamp_4_o(level_lamp_4_o));

// File: sim/pack_mode_charge_controller_tb.sv
`include "pack_ctrl_consts.vh"
module pack_mode_charge_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 4;
  logic clk_i = 1'h0;
  logic rst_b = 1'h0;
  logic park = 1'h0;
  logic pb_b = 1'h1;
  logic input_supply = 1'h0;
  logic ovl = 1'h0;
  logic [2:0] lvl = 3'h3;
  wire out_uv, bat_uv, pre_f, term_f, cur_f, rch_f, low_f, path, buck, bst, pcur, cv, uvl;
  wire [3:0] lev;
  wire [1:0] fl;
  wire [3:0] lamps;
  wire [1:0] mode;
  wire [2:0] st;
  int n_mismatch = 0;
  int checks = 0;
  // Free running clock
  always #2.5 clk_i = ~clk_i;
  power_stage_model stage_u (.lvl_i(lvl), .ovl_i(ovl), .path_i(path), .cv_i(cv), .out_uv_o(out_uv),
    .bat_uv_o(bat_uv), .precond_o(pre_f), .term_o(term_f), .cur_low_o(cur_f), .recharge_o(rch_f),
    .low_o(low_f), .level_o(lev));
  pack_mode_charge_controller #(.FLASHLIGHT(0), .TICK_CYCLES(TC)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b),
    .park_pin_i(park), .push_button_b_i(pb_b), .input_supply_valid_i(input_supply), .out_undervolt_i(out_uv),
    .bat_undervolt_i(bat_uv), .bat_above_precond_i(pre_f), .bat_at_term_i(term_f),
    .chg_current_low_i(cur_f), .bat_recharge_i(rch_f), .bat_above_low_i(low_f), .bat_above_level_i(lev),
    .input_path_switch_o(path), .converter_buck_o(buck), .converter_boost_o(bst), .precond_current_o(pcur),
    .const_voltage_o(cv), .flashlight_o(fl[0]), .mode_o(mode), .chg_state_o(st), .uv_latched_o(uvl),
    .level_lamp_1_o(lamps[0]), .level_lamp_2_o(lamps[1]), .level_lamp_3_o(lamps[2]),
    .level_lamp_4_o(lamps[3]));
  // Flashlight variant on the same pins and flags
  pack_mode_charge_controller #(.FLASHLIGHT(1), .TICK_CYCLES(TC)) flash_u (.clk_i(clk_i), .rst_b_i(rst_b),
    .park_pin_i(park), .push_button_b_i(pb_b), .input_supply_valid_i(input_supply), .out_undervolt_i(out_uv),
    .bat_undervolt_i(bat_uv), .bat_above_precond_i(pre_f), .bat_at_term_i(term_f),
    .chg_current_low_i(cur_f), .bat_recharge_i(rch_f), .bat_above_low_i(low_f), .bat_above_level_i(lev),
    .input_path_switch_o(), .converter_buck_o(), .converter_boost_o(), .precond_current_o(),
    .const_voltage_o(), .flashlight_o(fl[1]), .mode_o(), .chg_state_o(), .uv_latched_o(),
    .level_lamp_1_o(), .level_lamp_2_o(), .level_lamp_3_o(), .level_lamp_4_o());
  // Comparison and bookkeeping
  task chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task wait_mode(input logic [1:0] m, input int lim);
    for (int i = 0; i < lim && mode !== m; i++) @(posedge clk_i);
  endtask
  task press(input int ms);
    pb_b <= 1'h0;
    cy(ms * TC);
    pb_b <= 1'h1;
    cy(20);
  endtask
  task t_boost;
    press(20);
    cy(8200);
    chk(mode, `MODE_PARK, "short press started boost");
    press(40);
    wait_mode(`MODE_BOOST, 400);
    cy(2);
    chk({path, bst}, 2'h1, "boost switches");
    chk(lamps, 4'h3, "boost lamps");
    $display("t_boost done");
  endtask
  task t_off;
    int i;
    pb_b <= 1'h0;
    for (i = 0; i < 7000 && mode !== `MODE_PARK; i++) @(posedge clk_i);
    chk(i > 1500 * TC && i < 1510 * TC, 1'h1, "boost off timing");
    pb_b <= 1'h1;
    cy(100);
    chk(lamps, 4'h3, "lamps shown after release");
    cy(5100 * TC);
    chk(lamps, 4'h0, "lamps still shown");
    $display("t_off done");
  endtask
  task t_uv;
    press(40);
    wait_mode(`MODE_BOOST, 400);
    lvl <= 3'h0;
    wait_mode(`MODE_PARK, 100);
    cy(4);
    chk({mode, uvl}, 3'h1, "undervoltage latch");
    press(40);
    park <= 1'h1;
    cy(20);
    park <= 1'h0;
    cy(9000);
    chk({mode, uvl}, 3'h1, "latch released by pins");
    $display("t_uv done");
  endtask
  task t_charge;
    int cnt;
    lvl <= 3'h1;
    input_supply <= 1'h1;
    wait_mode(`MODE_CHARGE, 9000);
    cy(4);
    chk(uvl, 1'h0, "latch kept after supply");
    chk({st, pcur}, 4'h1, "precondition");
    chk({path, buck}, 2'h3, "charge switches");
    cnt = 0;
    for (int i = 0; i < 2000 * TC; i++) begin
      @(posedge clk_i);
      cnt += (lamps[0] === 1'h1);
    end
    chk(cnt > 1000 * TC - 12 && cnt < 1000 * TC + 12, 1'h1, "flash duty");
    chk(lamps[3:1], 3'h0, "upper lamps on");
    lvl <= 3'h2;
    cy(10);
    chk({st, pcur}, 4'h2, "fast charge");
    chk(lamps[0], 1'h1, "passed lamp solid");
    lvl <= 3'h6;
    cy(20);
    chk(st, `CHG_EOC, "end of charge");
    cy(10);
    chk(lamps, 4'hf, "end lamps");
    lvl <= 3'h4;
    cy(10);
    chk(st, `CHG_FAST, "recharge");
    $display("t_charge done");
  endtask
  task t_hiccup;
    int i;
    ovl <= 1'h1;
    cy(10);
    chk(path, 1'h0, "path kept on");
    ovl <= 1'h0;
    for (i = 10; i < 9000 && path !== 1'h1; i++) @(posedge clk_i);
    chk(i >= 1995 * TC && i <= 2005 * TC, 1'h1, "retry timing");
    $display("t_hiccup done");
  endtask
  task t_flash;
    chk(fl, 2'h0, "flashlight on early");
    press(3050);
    chk(fl, 2'h2, "flashlight not switched on");
    press(3050);
    chk(fl, 2'h0, "flashlight not switched off");
    $display("t_flash done");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    cy(12);
    chk({path, buck, bst, uvl}, 4'h0, "reset outputs");
    chk({mode, st}, 5'h04, "reset state");
    rst_b <= 1'h1;
    t_boost();
    t_off();
    t_uv();
    t_charge();
    t_hiccup();
    t_flash();
    test_done();
  end
  // Watchdog
  initial begin
    #470000;
    n_mismatch++;
    test_done();
  end
endmodule
